// ### core/scr_control_regs.v
// Decode and apply the synthesizer control words for registers 0 to 4
`timescale 1ns/100ps
`include "scr_defines.vh"
module scr_control_regs #(
   parameter RW  = 10,
   parameter MW  = 12,
   parameter BSW = 8
) (
   // Clock and reset
   input  wire           i_clk,
   input  wire           i_rst_n,
   // Latched serial word
   input  wire [31:0]    i_word,
   input  wire           i_word_stb,
   // Reference path events (already in i_clk domain)
   input  wire           i_ref_edge,
   // Lock comparison: one strobe per cycle with measured phase error in ns
   input  wire           i_cmp_stb,
   input  wire [7:0]     i_cmp_err_ns,
   // Register 1 fields
   output reg  [MW-1:0]  o_fractional_modulus,
   output reg  [MW-1:0]  o_phase_word,
   // Register 2 fields
   output reg  [1:0]     o_noise_mode,
   output wire           o_dither_en,
   output reg  [2:0]     o_output_multiplexer,
   output reg            o_ref_doubler,
   output wire           o_ref_both_edges,
   output reg            o_reference_half_divider,
   output reg  [RW-1:0]  o_ref_count,
   output reg            o_double_buffer,
   output reg  [3:0]     o_cp_current,
   output reg            o_lock_detect_function,
   output reg            o_lock_detect_precision,
   output reg            o_pd_polarity,
   output reg            o_power_down,
   output wire           o_cp_three_state,
   output wire           o_counter_reset,
   output wire           o_vco_off,
   output wire           o_rf_out_en,
   // Register 3 fields
   output reg            o_cycle_slip_reduction,
   output reg  [1:0]     o_clk_div_mode,
   output wire           o_phase_resync_en,
   output wire           o_fast_lock_en,
   output reg  [MW-1:0]  o_clk_div_value,
   // Register 4 fields
   output reg            o_fb_from_vco,
   output reg  [2:0]     o_out_div_sel,
   output reg  [BSW-1:0] o_band_sel_div,
   output reg            o_mute_till_lock,
   // Derived reference and status
   output reg            o_pfd_ref_tick,
   output reg            o_band_sel_tick,
   output wire           o_locked
);
   wire [2:0] sel = i_word[`SCR_SEL_MSB:`SCR_SEL_LSB];
   // One-hot write decode; selects 5 to 7 fall to the default and are dropped
   reg  [4:0] wr_hot;
   always @* begin
      wr_hot = 5'h00;
      // Writes are acted on only when the shifter presents a whole word
      if (i_word_stb) begin
         case (sel)
            `SCR_SEL_R0: wr_hot = 5'h01;
            `SCR_SEL_R1: wr_hot = 5'h02;
            `SCR_SEL_R2: wr_hot = 5'h04;
            `SCR_SEL_R3: wr_hot = 5'h08;
            `SCR_SEL_R4: wr_hot = 5'h10;
            default:     wr_hot = 5'h00;
         endcase
      end
   end
   wire       wr0 = wr_hot[0];
   wire       wr1 = wr_hot[1];
   wire       wr2 = wr_hot[2];
   wire       wr3 = wr_hot[3];
   wire       wr4 = wr_hot[4];

   // Shadow copies for double-buffered fields, plus the stored three-state and counter reset bits
   reg           sh_dbl;
   reg           sh_half;
   reg [RW-1:0]  sh_rcnt;
   reg [3:0]     sh_cp;
   reg [2:0]     sh_div;
   reg           cp_tri_bit;
   reg           crst_bit;

   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_fractional_modulus     <= {MW{1'b0}};
         o_phase_word             <= {MW{1'b0}};
         o_noise_mode             <= 2'h0;
         o_output_multiplexer     <= 3'h0;
         o_ref_doubler            <= 1'b0;
         o_reference_half_divider <= 1'b0;
         o_ref_count              <= {RW{1'b0}};
         o_double_buffer          <= 1'b0;
         o_cp_current             <= 4'h0;
         o_lock_detect_function   <= 1'b0;
         o_lock_detect_precision  <= 1'b0;
         o_pd_polarity            <= 1'b0;
         o_power_down             <= 1'b0;
         cp_tri_bit               <= 1'b0;
         crst_bit                 <= 1'b0;
         o_cycle_slip_reduction   <= 1'b0;
         o_clk_div_mode           <= 2'h0;
         o_clk_div_value          <= {MW{1'b0}};
         o_fb_from_vco            <= 1'b0;
         o_out_div_sel            <= 3'h0;
         o_band_sel_div           <= {BSW{1'b0}};
         o_mute_till_lock         <= 1'b0;
         sh_dbl                   <= 1'b0;
         sh_half                  <= 1'b0;
         sh_rcnt                  <= {RW{1'b0}};
         sh_cp                    <= 4'h0;
         sh_div                   <= 3'h0;
      end else begin
         if (wr1) begin
            o_fractional_modulus <= i_word[`SCR_R1_MOD_MSB:`SCR_R1_MOD_LSB];
            o_phase_word         <= i_word[`SCR_R1_PH_MSB:`SCR_R1_PH_LSB];
         end
         if (wr2) begin
            o_noise_mode            <= i_word[`SCR_R2_NOISE_MSB:`SCR_R2_NOISE_LSB];
            o_output_multiplexer    <= i_word[`SCR_R2_MUX_MSB:`SCR_R2_MUX_LSB];
            sh_dbl                  <= i_word[`SCR_R2_DBL];
            sh_half                 <= i_word[`SCR_R2_HALF];
            sh_rcnt                 <= i_word[`SCR_R2_RCNT_MSB:`SCR_R2_RCNT_LSB];
            o_double_buffer         <= i_word[`SCR_R2_DBUF];
            sh_cp                   <= i_word[`SCR_R2_CP_MSB:`SCR_R2_CP_LSB];
            o_lock_detect_function  <= i_word[`SCR_R2_LDF];
            o_lock_detect_precision <= i_word[`SCR_R2_LDP];
            o_pd_polarity           <= i_word[`SCR_R2_POL];
            // Register contents are kept through power-down
            o_power_down            <= i_word[`SCR_R2_PD];
            cp_tri_bit              <= i_word[`SCR_R2_TRI];
            crst_bit                <= i_word[`SCR_R2_CRST];
         end
         if (wr3) begin
            o_cycle_slip_reduction <= i_word[`SCR_R3_CSR];
            o_clk_div_mode         <= i_word[`SCR_R3_CDM_MSB:`SCR_R3_CDM_LSB];
            o_clk_div_value        <= i_word[`SCR_R3_CDIV_MSB:`SCR_R3_CDIV_LSB];
         end
         if (wr4) begin
            o_fb_from_vco    <= i_word[`SCR_R4_FB];
            sh_div           <= i_word[`SCR_R4_DIV_MSB:`SCR_R4_DIV_LSB];
            o_band_sel_div   <= i_word[`SCR_R4_BS_MSB:`SCR_R4_BS_LSB];
            o_mute_till_lock <= i_word[`SCR_R4_MTLD];
         end
         // Buffered fields move to the active copy on a register 0 write
         if (wr0) begin
            o_ref_doubler            <= sh_dbl;
            o_reference_half_divider <= sh_half;
            o_ref_count              <= sh_rcnt;
            o_cp_current             <= sh_cp;
         end
         // Divider select is immediate unless buffering is enabled
         if (wr4 && !o_double_buffer) begin
            o_out_div_sel <= i_word[`SCR_R4_DIV_MSB:`SCR_R4_DIV_LSB];
         end else if (wr0 && o_double_buffer) begin
            o_out_div_sel <= sh_div;
         end
      end
   end

   assign o_dither_en      = (o_noise_mode == `SCR_NOISE_LOWSPUR);
   assign o_ref_both_edges = o_ref_doubler;
   assign o_cp_three_state = cp_tri_bit | o_power_down;
   assign o_counter_reset  = crst_bit | o_power_down;
   assign o_vco_off        = o_power_down;
   assign o_phase_resync_en = (o_clk_div_mode == `SCR_CDM_RESYNC);
   assign o_fast_lock_en    = (o_clk_div_mode == `SCR_CDM_FASTLOCK);
   // Muted outputs stay off until lock so no off-frequency energy leaks out
   assign o_rf_out_en = !o_power_down && !(o_mute_till_lock && !o_locked);

   // Reference counter; ratio 0 is treated as 1 since 0 is not a legal ratio
   reg [RW-1:0] rcnt;
   reg          half_q;
   wire [RW-1:0] ratio = (o_ref_count == {RW{1'b0}}) ? {{(RW-1){1'b0}}, 1'b1} : o_ref_count;
   wire          r_out = i_ref_edge && (rcnt + 1'b1 >= ratio);

   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rcnt   <= {RW{1'b0}};
         half_q <= 1'b0;
      end else if (o_counter_reset) begin
         // Held at load state while reset or powered down
         rcnt   <= {RW{1'b0}};
         half_q <= 1'b0;
      end else if (i_ref_edge) begin
         rcnt <= r_out ? {RW{1'b0}} : rcnt + 1'b1;
         if (r_out) begin
            half_q <= ~half_q;
         end
      end
   end

   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_pfd_ref_tick <= 1'b0;
      end else begin
         // Toggle stage halves the rate: tick on every other counter output
         o_pfd_ref_tick <= r_out && !o_counter_reset &&
                           (!o_reference_half_divider || half_q);
      end
   end

   // Band select clock divider on the reference counter output
   reg [BSW-1:0] bscnt;
   wire [BSW-1:0] bs_ratio = (o_band_sel_div == {BSW{1'b0}}) ?
                             {{(BSW-1){1'b0}}, 1'b1} : o_band_sel_div;
   wire bs_hit = r_out && (bscnt + 1'b1 >= bs_ratio);

   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         bscnt           <= {BSW{1'b0}};
         o_band_sel_tick <= 1'b0;
      end else if (o_counter_reset) begin
         bscnt           <= {BSW{1'b0}};
         o_band_sel_tick <= 1'b0;
      end else begin
         o_band_sel_tick <= bs_hit;
         if (r_out) begin
            bscnt <= bs_hit ? {BSW{1'b0}} : bscnt + 1'b1;
         end
      end
   end

   // Window and run length per lock mode; integer mode reverses the precision sense
   reg  [7:0] win_ns;
   reg  [5:0] need;
   always @* begin
      win_ns = `SCR_WIN_WIDE_NS;
      need   = `SCR_LD_FRACTION_NUMERATOR_CNT;
      case ({o_lock_detect_function, o_lock_detect_precision})
         2'h0: begin
            win_ns = `SCR_WIN_WIDE_NS;
            need   = `SCR_LD_FRACTION_NUMERATOR_CNT;
         end
         2'h1: begin
            win_ns = `SCR_WIN_NARROW_NS;
            need   = `SCR_LD_FRACTION_NUMERATOR_CNT;
         end
         2'h2: begin
            win_ns = `SCR_WIN_NARROW_NS;
            need   = `SCR_LD_INT_CNT;
         end
         2'h3: begin
            win_ns = `SCR_WIN_WIDE_NS;
            need   = `SCR_LD_INT_CNT;
         end
         default: begin
            win_ns = `SCR_WIN_WIDE_NS;
            need   = `SCR_LD_FRACTION_NUMERATOR_CNT;
         end
      endcase
   end
   // Changing mode restarts detection so a stale count cannot carry over
   reg        ldf_q;
   reg        ldp_q;
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ldf_q <= 1'b0;
         ldp_q <= 1'b0;
      end else begin
         ldf_q <= o_lock_detect_function;
         ldp_q <= o_lock_detect_precision;
      end
   end
   wire ld_clear = o_power_down || (ldf_q != o_lock_detect_function) ||
                   (ldp_q != o_lock_detect_precision);

   scr_lock_detect #(
      .CW (6)
   ) u_lock (
      .i_clk       (i_clk),
      .i_rst_n     (i_rst_n),
      .i_clear     (ld_clear),
      .i_need      (need),
      .i_cmp_stb   (i_cmp_stb),
      .i_in_window (i_cmp_err_ns < win_ns),
      .o_locked    (o_locked)
   );
endmodule // scr_control_regs

// ### core/scr_defines.vh
// Field positions, select codes and timing constants of the synthesizer control registers
`ifndef SCR_DEFINES_VH
`define SCR_DEFINES_VH
`define SCR_SEL_LSB      0
`define SCR_SEL_MSB      2
`define SCR_SEL_R0       3'h0
`define SCR_SEL_R1       3'h1
`define SCR_SEL_R2       3'h2
`define SCR_SEL_R3       3'h3
`define SCR_SEL_R4       3'h4
`define SCR_R1_MOD_LSB   3
`define SCR_R1_MOD_MSB   14
`define SCR_R1_PH_LSB    15
`define SCR_R1_PH_MSB    26
`define SCR_R2_NOISE_MSB 30
`define SCR_R2_NOISE_LSB 29
`define SCR_R2_MUX_MSB   28
`define SCR_R2_MUX_LSB   26
`define SCR_R2_DBL       25
`define SCR_R2_HALF      24
`define SCR_R2_RCNT_MSB  23
`define SCR_R2_RCNT_LSB  14
`define SCR_R2_DBUF      13
`define SCR_R2_CP_MSB    12
`define SCR_R2_CP_LSB    9
`define SCR_R2_LDF       8
`define SCR_R2_LDP       7
`define SCR_R2_POL       6
`define SCR_R2_PD        5
`define SCR_R2_TRI       4
`define SCR_R2_CRST      3
`define SCR_R3_CSR       18
`define SCR_R3_CDM_MSB   16
`define SCR_R3_CDM_LSB   15
`define SCR_R3_CDIV_MSB  14
`define SCR_R3_CDIV_LSB  3
`define SCR_R4_FB        23
`define SCR_R4_DIV_MSB   22
`define SCR_R4_DIV_LSB   20
`define SCR_R4_BS_MSB    19
`define SCR_R4_BS_LSB    12
`define SCR_R4_MTLD      10
`define SCR_NOISE_LOWSPUR 2'h3
`define SCR_CDM_FASTLOCK 2'h1
`define SCR_CDM_RESYNC   2'h2
`define SCR_LD_FRACTION_NUMERATOR_CNT  6'h28
`define SCR_LD_INT_CNT   6'h05
`define SCR_WIN_WIDE_NS   8'h0a
`define SCR_WIN_NARROW_NS 8'h06
`endif

// ### core/scr_lock_detect.v
// Digital lock detector counting consecutive in-window comparison cycles
`timescale 1ns/100ps
module scr_lock_detect #(
   parameter CW = 6
) (
   // Clock and reset
   input  wire          i_clk,
   input  wire          i_rst_n,
   // Control
   input  wire          i_clear,
   input  wire [CW-1:0] i_need,
   // Comparison events
   input  wire          i_cmp_stb,
   input  wire          i_in_window,
   // Result
   output reg           o_locked
);
   reg [CW-1:0] run;

   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         run      <= {CW{1'b0}};
         o_locked <= 1'b0;
      end else if (i_clear) begin
         run      <= {CW{1'b0}};
         o_locked <= 1'b0;
      end else if (i_cmp_stb) begin
         if (!i_in_window) begin
            // Any wide cycle restarts the count and drops lock
            run      <= {CW{1'b0}};
            o_locked <= 1'b0;
         end else if (run + 1'b1 >= i_need) begin
            run      <= i_need;
            o_locked <= 1'b1;
         end else begin
            run <= run + 1'b1;
         end
      end
   end
endmodule // scr_lock_detect

// ### tb/scr_control_regs_chk.sv
// Port-level assertions for the control register block
`timescale 1ns/100ps
module scr_control_regs_chk #(
   parameter BSW = 8
) (
   input wire logic           i_clk,
   input wire logic           i_rst_n,
   input wire logic [31:0]    i_word,
   input wire logic           i_word_stb,
   input wire logic           i_cmp_stb,
   input wire logic [7:0]     i_cmp_err_ns,
   input wire logic [1:0]     o_noise_mode,
   input wire logic           o_dither_en,
   input wire logic [2:0]     o_output_multiplexer,
   input wire logic           o_lock_detect_function,
   input wire logic           o_lock_detect_precision,
   input wire logic           o_power_down,
   input wire logic           o_cp_three_state,
   input wire logic           o_counter_reset,
   input wire logic           o_vco_off,
   input wire logic           o_rf_out_en,
   input wire logic           o_cycle_slip_reduction,
   input wire logic [1:0]     o_clk_div_mode,
   input wire logic           o_fb_from_vco,
   input wire logic [BSW-1:0] o_band_sel_div,
   input wire logic           o_mute_till_lock,
   input wire logic           o_locked
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   // Window limit in ns for the active lock mode
   wire [7:0] lim = (o_lock_detect_function ^ o_lock_detect_precision) ? 8'h06 : 8'h0a;
   a_reg2_fields: assert property (i_word_stb && i_word[2:0] == 3'h2 |=>
      o_noise_mode == $past(i_word[30:29]) && o_output_multiplexer == $past(i_word[28:26])
      && o_power_down == $past(i_word[5])) else $error("reg2 fields not applied");
   a_reg3_fields: assert property (i_word_stb && i_word[2:0] == 3'h3 |=>
      o_clk_div_mode == $past(i_word[16:15]) && o_cycle_slip_reduction == $past(i_word[18]))
      else $error("reg3 fields not applied");
   a_reg4_fields: assert property (i_word_stb && i_word[2:0] == 3'h4 |=>
      o_fb_from_vco == $past(i_word[23]) && o_band_sel_div == $past(i_word[19:12]))
      else $error("reg4 fields not applied");
   a_fields_hold: assert property (!i_word_stb |=>
      $stable({o_noise_mode, o_output_multiplexer, o_clk_div_mode, o_fb_from_vco}))
      else $error("field moved without a word");
   a_dither_mode: assert property (o_dither_en == (o_noise_mode == 2'h3))
      else $error("dither does not follow noise mode");
   a_pd_effects: assert property (o_power_down |->
      o_cp_three_state && o_counter_reset && o_vco_off && !o_rf_out_en)
      else $error("power-down effects missing");
   a_pd_unlock: assert property (o_power_down ##1 o_power_down |-> !o_locked)
      else $error("lock held in power-down");
   a_out_window: assert property (i_cmp_stb && i_cmp_err_ns >= lim |=> ##[0:1] !o_locked)
      else $error("lock kept after out-of-window compare");
   a_lock_cause: assert property ($rose(o_locked) |->
      $past(i_cmp_stb) && $past(i_cmp_err_ns) < $past(lim)) else $error("lock without compare");
   a_mute_lock: assert property (o_mute_till_lock && !o_locked |-> !o_rf_out_en)
      else $error("output live before lock");
   cover property (o_locked && o_rf_out_en && o_mute_till_lock);
   cover property (o_power_down);
   cover property (o_clk_div_mode == 2'h2);
endmodule // scr_control_regs_chk
bind scr_control_regs scr_control_regs_chk #(.BSW(BSW)) u_scr_control_regs_chk (.*);

// ### tb/scr_control_regs_tb_top.sv
// Self-checking testbench for the control register block
`timescale 1ns/100ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_fail++; \
   $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module scr_control_regs_tb_top;
   logic i_clk = 1'b0, i_rst_n = 1'b0, i_ref_edge, i_word_stb, i_cmp_stb;
   logic [31:0] i_word;
   logic [7:0] i_cmp_err_ns;
   wire [11:0] fractional_modulus, ph, cdv;
   wire [9:0] rc;
   wire [7:0] bsd;
   wire [3:0] cp;
   wire [2:0] mx, ods;
   wire [1:0] nm, cdm;
   wire dth, dbl, bth, hlf, dbf, lock_detect_function, lock_detect_precision, pol, pd, tri3, crs, vof, rfe, cycle_slip_reduction, rsy, fst, fbv, mtl;
   wire tck, btk, lck;
   int n_fail = 0, check_count = 0, n_tick, n_btk;
   always #4 i_clk = ~i_clk;
   always @(posedge i_clk) if (tck) n_tick <= n_tick + 1;
   always @(posedge i_clk) if (btk) n_btk <= n_btk + 1;
   scr_host_model u_scr_host_model (.i_clk(i_clk), .o_word(i_word), .o_word_stb(i_word_stb),
      .o_ref_edge(i_ref_edge), .o_cmp_stb(i_cmp_stb), .o_cmp_err_ns(i_cmp_err_ns));
   scr_control_regs u_scr_control_regs (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_word(i_word),
      .i_word_stb(i_word_stb), .i_ref_edge(i_ref_edge), .i_cmp_stb(i_cmp_stb),
      .i_cmp_err_ns(i_cmp_err_ns), .o_fractional_modulus(fractional_modulus), .o_phase_word(ph),
      .o_noise_mode(nm), .o_dither_en(dth), .o_output_multiplexer(mx), .o_ref_doubler(dbl),
      .o_ref_both_edges(bth), .o_reference_half_divider(hlf), .o_ref_count(rc),
      .o_double_buffer(dbf), .o_cp_current(cp), .o_lock_detect_function(lock_detect_function),
      .o_lock_detect_precision(lock_detect_precision), .o_pd_polarity(pol), .o_power_down(pd),
      .o_cp_three_state(tri3), .o_counter_reset(crs), .o_vco_off(vof), .o_rf_out_en(rfe),
      .o_cycle_slip_reduction(cycle_slip_reduction), .o_clk_div_mode(cdm), .o_phase_resync_en(rsy),
      .o_fast_lock_en(fst), .o_clk_div_value(cdv), .o_fb_from_vco(fbv), .o_out_div_sel(ods),
      .o_band_sel_div(bsd), .o_mute_till_lock(mtl), .o_pfd_ref_tick(tck),
      .o_band_sel_tick(btk), .o_locked(lck));
   // Flags f = {doubler, half, dbuf, ldf, ldp, polarity, pd, tri, counter reset}
   function automatic logic [31:0] r2(logic [1:0] n, logic [2:0] m, logic [9:0] r,
                                      logic [3:0] c, logic [8:0] f);
      r2 = {1'b0, n, m, f[8:7], r, f[6], c, f[5:0], 3'h2};
   endfunction
   function automatic logic [31:0] r4(logic [2:0] d, logic m, logic [2:0] s);
      r4 = {8'h0, 1'b1, d, 8'h7e, 1'b0, m, 7'h0, s};
   endfunction
   task put(input logic [31:0] w);
      u_scr_host_model.send(w);
      @(negedge i_clk);
   endtask
   task done(input string t);
      $display("test %s done", t);
   endtask
   task tally_and_finish;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial begin
      #200000;
      n_fail++;
      tally_and_finish();
   end
   initial begin
      repeat (6) @(posedge i_clk);
      i_rst_n <= 1'b1;
      @(negedge i_clk);
      `CHK("rf_en", 1'b1, rfe)
      put({5'h0, 12'h001, 12'h019, 3'h1});
      `CHK("phase", 12'h001, ph)
      `CHK("mod", 12'h019, fractional_modulus)
      done("reset_reg1");
      for (int k = 0; k < 8; k++) begin
         put(r2(k[1:0], k[2:0], 10'h003, 4'h9, 9'h188));
         `CHK("dither", k[1:0] == 2'h3, dth)
         `CHK("mux", k[2:0], mx)
         `CHK("rcnt_held", 10'h000, rc)
      end
      `CHK("pol", 1'b1, pol)
      put(32'h0);
      `CHK("rcnt", 10'h003, rc)
      `CHK("dbl", 1'b1, bth)
      `CHK("dbl_act", 1'b1, dbl)
      `CHK("half", 1'b1, hlf)
      `CHK("cp", 4'h9, cp)
      n_tick = 0;
      n_btk = 0;
      u_scr_host_model.refs(12);
      repeat (3) @(posedge i_clk);
      `CHK("ticks", 2, n_tick)
      `CHK("band_ticks", 4, n_btk)
      done("reg2");
      for (int m = 0; m < 3; m++) begin
         put({13'h0, 1'b1, 1'b0, m[1:0], 12'habc, 3'h3});
         `CHK("csr", 1'b1, cycle_slip_reduction)
         `CHK("resync", m == 2, rsy)
         `CHK("fast", m == 1, fst)
         `CHK("cdiv", 12'habc, cdv)
      end
      done("reg3");
      put(r4(3'h5, 1'b1, 3'h4));
      `CHK("fb", 1'b1, fbv)
      `CHK("div", 3'h5, ods)
      `CHK("bsd", 8'h7e, bsd)
      `CHK("muted", 1'b0, rfe)
      for (int s = 5; s < 8; s++) put(r4(3'h1, 1'b0, s[2:0]));
      `CHK("ignored", 1'b1, mtl)
      put(r2(2'h0, 3'h0, 10'h003, 4'h9, 9'h1c8));
      `CHK("dbuf", 1'b1, dbf)
      put(r4(3'h3, 1'b1, 3'h4));
      `CHK("div_held", 3'h5, ods)
      put(32'h0);
      `CHK("div_new", 3'h3, ods)
      done("reg4");
      put(r2(2'h0, 3'h0, 10'h003, 4'h9, 9'h188));
      u_scr_host_model.compare(39, 8'h09);
      @(negedge i_clk);
      `CHK("lock39", 1'b0, lck)
      u_scr_host_model.compare(1, 8'h09);
      @(negedge i_clk);
      `CHK("lock40", 1'b1, lck)
      `CHK("unmuted", 1'b1, rfe)
      u_scr_host_model.compare(1, 8'h0a);
      repeat (2) @(negedge i_clk);
      `CHK("unlock", 1'b0, lck)
      put(r2(2'h0, 3'h0, 10'h003, 4'h9, 9'h1b8));
      `CHK("ldf", 1'b1, lock_detect_function)
      `CHK("ldp", 1'b1, lock_detect_precision)
      u_scr_host_model.compare(4, 8'h09);
      @(negedge i_clk);
      `CHK("ilock4", 1'b0, lck)
      u_scr_host_model.compare(1, 8'h09);
      @(negedge i_clk);
      `CHK("ilock5", 1'b1, lck)
      done("lock");
      put(r2(2'h0, 3'h0, 10'h003, 4'h9, 9'h1bc));
      repeat (2) @(negedge i_clk);
      `CHK("pd_lock", 1'b0, lck)
      `CHK("pd_vco", 1'b1, vof)
      `CHK("pd_cnt", 1'b1, crs)
      `CHK("pd_keep", 8'h7e, bsd)
      put(r2(2'h0, 3'h0, 10'h003, 4'h9, 9'h1bb));
      `CHK("tri", 1'b1, tri3)
      `CHK("crst", 1'b1, crs)
      `CHK("pd_off", 1'b0, pd)
      done("power");
      // Fractional mode with the narrow window must refuse a 6 ns error
      put(r2(2'h0, 3'h0, 10'h003, 4'h9, 9'h198));
      u_scr_host_model.compare(40, 8'h06);
      @(negedge i_clk);
      `CHK("narrow", 1'b0, lck)
      done("narrow");
      tally_and_finish();
   end
endmodule // scr_control_regs_tb_top

// ### tb/scr_host_model.sv
// Host-side model driving words, reference edges and phase comparisons
`timescale 1ns/100ps
module scr_host_model (
   // Clock
   input  wire logic        i_clk,
   // Toward the block
   output logic      [31:0] o_word,
   output logic             o_word_stb,
   output logic             o_ref_edge,
   output logic             o_cmp_stb,
   output logic      [7:0]  o_cmp_err_ns
);
   initial begin
      o_word = 32'h0;
      o_word_stb = 1'b0;
      o_ref_edge = 1'b0;
      o_cmp_stb = 1'b0;
      o_cmp_err_ns = 8'h0;
   end
   // Released lines show inverted data so stale values cannot pass
   task send(input logic [31:0] w);
      @(posedge i_clk);
      o_word <= w;
      o_word_stb <= 1'b1;
      @(posedge i_clk);
      o_word <= ~w;
      o_word_stb <= 1'b0;
   endtask
   task compare(input int n, input logic [7:0] err);
      repeat (n) begin
         @(posedge i_clk);
         o_cmp_stb <= 1'b1;
         o_cmp_err_ns <= err;
         @(posedge i_clk);
         o_cmp_stb <= 1'b0;
         o_cmp_err_ns <= ~err;
      end
   endtask
   task refs(input int n);
      repeat (n) begin
         @(posedge i_clk);
         o_ref_edge <= 1'b1;
         @(posedge i_clk);
         o_ref_edge <= 1'b0;
      end
   endtask
endmodule // scr_host_model
